// [verilog/ripc_regs.v]
// Function
// - mic one source: 00 differential, 01 positive pin, 10 negative pin, 11 reserved.
// - mic two source: same decode, two bits, reset zero.
// - mic two control bit 7 enables amplifier, reset zero.
// - mic two control bit 6 mutes amplifier, reset one.
// - mic two gain three bits, -6 to 36 dB, reset code 001.
// - bias control bits 6:4 set bias two level, reset zero.
// - bias control bits 2:0 set bias one level, reset zero.
// - bias control bit 7 and bit 3 select low-power modes, reset zero.
// - bias enable bit 4 and bit 0 turn biases on, reset zero.
// - mixer one control bit 7 enables amplifier, reset zero.
// - mixer one control bit 6 mutes amplifier, reset one.
// - mixer one bit 4 applies gain only at zero crossing.
// - mixer one bit 5 ramps gain and overrides zero cross on o_mixin1_gain_mode_zc only, not on o_input_mixer_one_zero_cross_update.
// - mixer one bit 3 enables the mixer, reset one.
// - mixer gain four bits, -4.5 to 18 dB, reset code 0011.
// - mic one control: enable bit 7 reset zero, mute bit 6 reset one.
// - mic one gain three bits, -6 to 36 dB, reset code 001.
`timescale 1ns/1ns
`include "ripc_defines.vh"

module ripc_regs
(
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  output reg o_rd_valid,
  output reg o_mic1_en,
  output reg o_mic1_mute,
  output reg [2:0] o_mic1_gain,
  output reg [1:0] o_mic1_src,
  output reg o_mic2_en,
  output reg o_mic2_mute,
  output reg [2:0] o_mic2_gain,
  output reg [1:0] o_mic2_src,
  output reg [2:0] o_bias1_level,
  output reg [2:0] o_bias2_level,
  output reg o_first_bias_low_power,
  output reg o_second_bias_low_power,
  output reg o_bias1_en,
  output reg o_bias2_en,
  output reg o_mixin1_en,
  output reg o_mixin1_mute,
  output reg o_mixin1_ramp,
  output reg o_input_mixer_one_zero_cross_update,
  output reg o_mixin1_mix_sel,
  output reg [3:0] o_mixin1_gain,
  output reg o_mixin1_gain_mode_ramp,
  output reg o_mixin1_gain_mode_zc,
  output reg o_mixin2_en,
  output reg o_mixin2_mute,
  output reg o_mixin2_ramp,
  output reg o_mixin2_zc,
  output reg o_mixin2_mix_sel,
  output reg [3:0] o_mixin2_gain
);

  wire [7:0] mic1_ctrl_q;
  wire [2:0] mic1_gain_q;
  wire [1:0] mic1_src_q;
  wire [7:0] mic2_ctrl_q;
  wire [2:0] mic2_gain_q;
  wire [1:0] mic2_src_q;
  wire [7:0] bias_ctrl_q;
  wire [7:0] bias_en_q;
  wire [7:0] mix1_ctrl_q;
  wire [3:0] mix1_gain_q;
  wire [7:0] mix2_ctrl_q;
  wire [3:0] mix2_gain_q;
  reg [7:0] rdata_d;
  wire wr_mic1_ctrl;
  wire wr_mic1_gain;
  wire wr_mic1_src;
  wire wr_mic2_ctrl;
  wire wr_mic2_gain;
  wire wr_mic2_src;
  wire wr_bias_ctrl;
  wire wr_bias_en;
  wire wr_mix1_ctrl;
  wire wr_mix1_gain;
  wire wr_mix2_ctrl;
  wire wr_mix2_gain;

  // one strobe per register; an address outside the map matches none, so that write is dropped
  assign wr_mic1_ctrl = i_wr_en && (i_addr == `RIPC_ADDR_MIC1_CTRL);
  assign wr_mic1_gain = i_wr_en && (i_addr == `RIPC_ADDR_MIC1_GAIN);
  assign wr_mic1_src = i_wr_en && (i_addr == `RIPC_ADDR_MIC1_SRC);
  assign wr_mic2_ctrl = i_wr_en && (i_addr == `RIPC_ADDR_MIC2_CTRL);
  assign wr_mic2_gain = i_wr_en && (i_addr == `RIPC_ADDR_MIC2_GAIN);
  assign wr_mic2_src = i_wr_en && (i_addr == `RIPC_ADDR_MIC2_SRC);
  assign wr_bias_ctrl = i_wr_en && (i_addr == `RIPC_ADDR_BIAS_CTRL);
  assign wr_bias_en = i_wr_en && (i_addr == `RIPC_ADDR_BIAS_EN);
  assign wr_mix1_ctrl = i_wr_en && (i_addr == `RIPC_ADDR_MIXIN1_CTRL);
  assign wr_mix1_gain = i_wr_en && (i_addr == `RIPC_ADDR_MIXIN1_GAIN);
  assign wr_mix2_ctrl = i_wr_en && (i_addr == `RIPC_ADDR_MIXIN2_CTRL);
  assign wr_mix2_gain = i_wr_en && (i_addr == `RIPC_ADDR_MIXIN2_GAIN);

  // reserved bits are masked off at the write so they never hold state
  ripc_field_reg
  #(.WIDTH(8), .RST_VAL(`RIPC_RST_AMP_CTRL), .WR_MASK(`RIPC_MASK_AMP_CTRL))
  i_mic1_ctrl
  (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wr(wr_mic1_ctrl),
    .i_wdata(i_wdata),
    .o_value(mic1_ctrl_q)
  );

  ripc_field_reg
  #(.WIDTH(3), .RST_VAL(`RIPC_RST_MIC_GAIN))
  i_mic1_gain
  (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wr(wr_mic1_gain),
    .i_wdata(i_wdata[2:0]),
    .o_value(mic1_gain_q)
  );

  ripc_field_reg
  #(.WIDTH(2), .RST_VAL(`RIPC_RST_SRC))
  i_mic1_src
  (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wr(wr_mic1_src),
    .i_wdata(i_wdata[1:0]),
    .o_value(mic1_src_q)
  );

  ripc_field_reg
  #(.WIDTH(8), .RST_VAL(`RIPC_RST_AMP_CTRL), .WR_MASK(`RIPC_MASK_AMP_CTRL))
  i_mic2_ctrl
  (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wr(wr_mic2_ctrl),
    .i_wdata(i_wdata),
    .o_value(mic2_ctrl_q)
  );

  ripc_field_reg
  #(.WIDTH(3), .RST_VAL(`RIPC_RST_MIC_GAIN))
  i_mic2_gain
  (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wr(wr_mic2_gain),
    .i_wdata(i_wdata[2:0]),
    .o_value(mic2_gain_q)
  );

  ripc_field_reg
  #(.WIDTH(2), .RST_VAL(`RIPC_RST_SRC))
  i_mic2_src
  (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wr(wr_mic2_src),
    .i_wdata(i_wdata[1:0]),
    .o_value(mic2_src_q)
  );

  // level and power mode are stored as written; software keeps the bias off while changing them
  ripc_field_reg
  #(.WIDTH(8), .RST_VAL(`RIPC_RST_BIAS_CTRL))
  i_bias_ctrl
  (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wr(wr_bias_ctrl),
    .i_wdata(i_wdata),
    .o_value(bias_ctrl_q)
  );

  ripc_field_reg
  #(.WIDTH(8), .RST_VAL(`RIPC_RST_BIAS_EN), .WR_MASK(`RIPC_MASK_BIAS_EN))
  i_bias_en
  (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wr(wr_bias_en),
    .i_wdata(i_wdata),
    .o_value(bias_en_q)
  );

  ripc_field_reg
  #(.WIDTH(8), .RST_VAL(`RIPC_RST_MIX_CTRL), .WR_MASK(`RIPC_MASK_MIX_CTRL))
  i_mix1_ctrl
  (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wr(wr_mix1_ctrl),
    .i_wdata(i_wdata),
    .o_value(mix1_ctrl_q)
  );

  ripc_field_reg
  #(.WIDTH(4), .RST_VAL(`RIPC_RST_MIX_GAIN))
  i_mix1_gain
  (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wr(wr_mix1_gain),
    .i_wdata(i_wdata[3:0]),
    .o_value(mix1_gain_q)
  );

  ripc_field_reg
  #(.WIDTH(8), .RST_VAL(`RIPC_RST_MIX_CTRL), .WR_MASK(`RIPC_MASK_MIX_CTRL))
  i_mix2_ctrl
  (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wr(wr_mix2_ctrl),
    .i_wdata(i_wdata),
    .o_value(mix2_ctrl_q)
  );

  ripc_field_reg
  #(.WIDTH(4), .RST_VAL(`RIPC_RST_MIX_GAIN))
  i_mix2_gain
  (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wr(wr_mix2_gain),
    .i_wdata(i_wdata[3:0]),
    .o_value(mix2_gain_q)
  );

  always @*
  begin
    rdata_d = 8'h00;
    case (i_addr)
      `RIPC_ADDR_MIC1_CTRL: rdata_d = mic1_ctrl_q;
      `RIPC_ADDR_MIC1_GAIN: rdata_d = {5'h00, mic1_gain_q};
      `RIPC_ADDR_MIC1_SRC: rdata_d = {6'h00, mic1_src_q};
      `RIPC_ADDR_MIC2_CTRL: rdata_d = mic2_ctrl_q;
      `RIPC_ADDR_MIC2_GAIN: rdata_d = {5'h00, mic2_gain_q};
      `RIPC_ADDR_MIC2_SRC: rdata_d = {6'h00, mic2_src_q};
      `RIPC_ADDR_BIAS_CTRL: rdata_d = bias_ctrl_q;
      `RIPC_ADDR_BIAS_EN: rdata_d = bias_en_q;
      `RIPC_ADDR_MIXIN1_CTRL: rdata_d = mix1_ctrl_q;
      `RIPC_ADDR_MIXIN1_GAIN: rdata_d = {4'h0, mix1_gain_q};
      `RIPC_ADDR_MIXIN2_CTRL: rdata_d = mix2_ctrl_q;
      `RIPC_ADDR_MIXIN2_GAIN: rdata_d = {4'h0, mix2_gain_q};
      default: rdata_d = 8'h00;
    endcase
  end

  // outputs are registered copies, so each field reaches the analog side one cycle after the write
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_rdata <= 8'h00;
      o_rd_valid <= 1'b0;
      o_mic1_en <= 1'b0;
      o_mic1_mute <= 1'b1;
      o_mic1_gain <= `RIPC_RST_MIC_GAIN;
      o_mic1_src <= `RIPC_RST_SRC;
      o_mic2_en <= 1'b0;
      o_mic2_mute <= 1'b1;
      o_mic2_gain <= `RIPC_RST_MIC_GAIN;
      o_mic2_src <= `RIPC_RST_SRC;
      o_bias1_level <= 3'h0;
      o_bias2_level <= 3'h0;
      o_first_bias_low_power <= 1'b0;
      o_second_bias_low_power <= 1'b0;
      o_bias1_en <= 1'b0;
      o_bias2_en <= 1'b0;
      o_mixin1_en <= 1'b0;
      o_mixin1_mute <= 1'b1;
      o_mixin1_ramp <= 1'b0;
      o_input_mixer_one_zero_cross_update <= 1'b0;
      o_mixin1_mix_sel <= 1'b1;
      o_mixin1_gain <= `RIPC_RST_MIX_GAIN;
      o_mixin1_gain_mode_ramp <= 1'b0;
      o_mixin1_gain_mode_zc <= 1'b0;
      o_mixin2_en <= 1'b0;
      o_mixin2_mute <= 1'b1;
      o_mixin2_ramp <= 1'b0;
      o_mixin2_zc <= 1'b0;
      o_mixin2_mix_sel <= 1'b1;
      o_mixin2_gain <= `RIPC_RST_MIX_GAIN;
    end
    else
    begin
      o_rdata <= i_rd_en ? rdata_d : 8'h00;
      o_rd_valid <= i_rd_en;
      o_mic1_en <= mic1_ctrl_q[`RIPC_BIT_AMP_EN];
      o_mic1_mute <= mic1_ctrl_q[`RIPC_BIT_AMP_MUTE];
      o_mic1_gain <= mic1_gain_q;
      o_mic1_src <= mic1_src_q;
      o_mic2_en <= mic2_ctrl_q[`RIPC_BIT_AMP_EN];
      o_mic2_mute <= mic2_ctrl_q[`RIPC_BIT_AMP_MUTE];
      o_mic2_gain <= mic2_gain_q;
      o_mic2_src <= mic2_src_q;
      o_bias2_level <= bias_ctrl_q[`RIPC_LSB_BIAS2_LVL +: 3];
      o_bias1_level <= bias_ctrl_q[`RIPC_LSB_BIAS1_LVL +: 3];
      o_second_bias_low_power <= bias_ctrl_q[`RIPC_BIT_BIAS2_LP];
      o_first_bias_low_power <= bias_ctrl_q[`RIPC_BIT_BIAS1_LP];
      o_bias2_en <= bias_en_q[`RIPC_BIT_BIAS2_EN];
      o_bias1_en <= bias_en_q[`RIPC_BIT_BIAS1_EN];
      o_mixin1_en <= mix1_ctrl_q[`RIPC_BIT_AMP_EN];
      o_mixin1_mute <= mix1_ctrl_q[`RIPC_BIT_AMP_MUTE];
      o_mixin1_ramp <= mix1_ctrl_q[`RIPC_BIT_MIX_RAMP];
      o_input_mixer_one_zero_cross_update <= mix1_ctrl_q[`RIPC_BIT_MIX_ZC];
      o_mixin1_mix_sel <= mix1_ctrl_q[`RIPC_BIT_MIX_SEL];
      o_mixin1_gain <= mix1_gain_q;
      // ramping wins, so o_mixin1_gain_mode_ramp and o_mixin1_gain_mode_zc are never both set
      o_mixin1_gain_mode_ramp <= mix1_ctrl_q[`RIPC_BIT_MIX_RAMP];
      o_mixin1_gain_mode_zc <= mix1_ctrl_q[`RIPC_BIT_MIX_ZC] & ~mix1_ctrl_q[`RIPC_BIT_MIX_RAMP];
      o_mixin2_en <= mix2_ctrl_q[`RIPC_BIT_AMP_EN];
      o_mixin2_mute <= mix2_ctrl_q[`RIPC_BIT_AMP_MUTE];
      o_mixin2_ramp <= mix2_ctrl_q[`RIPC_BIT_MIX_RAMP];
      o_mixin2_zc <= mix2_ctrl_q[`RIPC_BIT_MIX_ZC];
      o_mixin2_mix_sel <= mix2_ctrl_q[`RIPC_BIT_MIX_SEL];
      o_mixin2_gain <= mix2_gain_q;
    end
  end

endmodule

// one storage register with synchronous reset; the write mask keeps reserved bits at zero
module ripc_field_reg
#(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}},
  parameter [WIDTH-1:0] WR_MASK = {WIDTH{1'b1}}
)
(
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_wr,
  input wire [WIDTH-1:0] i_wdata,
  output reg [WIDTH-1:0] o_value
);

  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_value <= RST_VAL;
    end
    else if (i_wr)
    begin
      o_value <= i_wdata & WR_MASK;
    end
  end

endmodule

// [verilog/ripc_defines.vh]
`ifndef RIPC_DEFINES_VH
`define RIPC_DEFINES_VH

`define RIPC_ADDR_MIXIN1_CTRL 8'h2c
`define RIPC_ADDR_MIXIN1_GAIN 8'h2d
`define RIPC_ADDR_MIXIN2_CTRL 8'h2e
`define RIPC_ADDR_MIXIN2_GAIN 8'h2f
`define RIPC_ADDR_MIC1_CTRL 8'hb4
`define RIPC_ADDR_MIC1_GAIN 8'hb5
`define RIPC_ADDR_MIC1_SRC 8'hb7
`define RIPC_ADDR_MIC2_CTRL 8'hb8
`define RIPC_ADDR_MIC2_GAIN 8'hb9
`define RIPC_ADDR_MIC2_SRC 8'hbb
`define RIPC_ADDR_BIAS_CTRL 8'hfc
`define RIPC_ADDR_BIAS_EN 8'hfd

`define RIPC_BIT_AMP_EN 7
`define RIPC_BIT_AMP_MUTE 6
`define RIPC_BIT_MIX_RAMP 5
`define RIPC_BIT_MIX_ZC 4
`define RIPC_BIT_MIX_SEL 3
`define RIPC_BIT_BIAS2_LP 7
`define RIPC_BIT_BIAS1_LP 3
`define RIPC_BIT_BIAS2_EN 4
`define RIPC_BIT_BIAS1_EN 0
`define RIPC_LSB_BIAS2_LVL 4
`define RIPC_LSB_BIAS1_LVL 0

`define RIPC_RST_AMP_CTRL 8'h40
`define RIPC_RST_MIX_CTRL 8'h48
`define RIPC_RST_MIX_GAIN 4'h3
`define RIPC_RST_MIC_GAIN 3'h1
`define RIPC_RST_SRC 2'h0
`define RIPC_RST_BIAS_CTRL 8'h00
`define RIPC_RST_BIAS_EN 8'h00

`define RIPC_MASK_AMP_CTRL 8'hc0
`define RIPC_MASK_MIX_CTRL 8'hf8
`define RIPC_MASK_BIAS_EN 8'h11

`endif

// [tb/ripc_regs_monitor.sv]
`timescale 1ns/1ns
module ripc_mon
(
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire [7:0] o_rdata,
  input wire o_rd_valid,
  input wire o_mic2_en,
  input wire o_mic2_mute,
  input wire o_bias1_en,
  input wire o_mixin1_ramp,
  input wire o_mixin1_gain_mode_zc,
  input wire o_input_mixer_one_zero_cross_update
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  sequence s_wr(a); i_wr_en && i_addr == a; endsequence
  sequence s_rd(a); i_rd_en && i_addr == a; endsequence
  chk_mic2_enable: assert property (s_wr(8'hb8) |-> ##2 o_mic2_en == $past(i_wdata[7], 2))
    else $error("mic two enable wrong");
  chk_mic2_mute: assert property (s_wr(8'hb8) |-> ##2 o_mic2_mute == $past(i_wdata[6], 2))
    else $error("mic two mute wrong");
  chk_bias1_enable: assert property (s_wr(8'hfd) |-> ##2 o_bias1_en == $past(i_wdata[0], 2))
    else $error("bias one enable wrong");
  chk_ramp_overrides: assert property (o_mixin1_ramp |-> !o_mixin1_gain_mode_zc)
    else $error("zero cross active under ramp");
  chk_zero_cross: assert property (o_input_mixer_one_zero_cross_update && !o_mixin1_ramp |-> o_mixin1_gain_mode_zc)
    else $error("zero cross mode missing");
  chk_enable_reserved: assert property (s_rd(8'hfd) |=> o_rd_valid && (o_rdata & 8'hee) == 8'h00)
    else $error("reserved enable bits set");
  chk_source_reserved: assert property (s_rd(8'hb7) |=> o_rd_valid && o_rdata[7:2] == 6'h00)
    else $error("reserved source bits set");
  chk_unmapped_read: assert property (s_rd(8'hb6) |=> o_rd_valid && o_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind ripc_regs ripc_mon i_mon (.i_clk_sys, .i_rst, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .o_rdata, .o_rd_valid,
  .o_mic2_en, .o_mic2_mute, .o_bias1_en, .o_mixin1_ramp, .o_mixin1_gain_mode_zc, .o_input_mixer_one_zero_cross_update);

// [tb/ripc_regs_tb.sv]
`timescale 1ns/1ns
module ripc_regs_tb;
  localparam logic [7:0] ad_tab [12] = '{8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'hb4, 8'hb5, 8'hb7, 8'hb8, 8'hb9, 8'hbb, 8'hfc, 8'hfd};
  localparam logic [7:0] rv_tab [12] = '{8'h48, 8'h03, 8'h48, 8'h03, 8'h40, 8'h01, 8'h00, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] mk_tab [12] = '{8'hf8, 8'h0f, 8'hf8, 8'h0f, 8'hc0, 8'h07, 8'h03, 8'hc0, 8'h07, 8'h03, 8'hff, 8'h11};
  localparam logic [7:0] pat_tab [3] = '{8'hff, 8'ha5, 8'h5a};
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic [1:0] o_mic1_src, o_mic2_src;
  logic [2:0] o_bias1_level, o_bias2_level;
  logic o_rd_valid, o_mixin1_gain_mode_ramp, o_mixin1_gain_mode_zc;
  logic [2:0] o_mic1_gain, o_mic2_gain;
  logic [3:0] o_mixin1_gain, o_mixin2_gain;
  logic o_mic1_en, o_mic1_mute, o_mic2_en, o_mic2_mute, o_first_bias_low_power, o_second_bias_low_power;
  logic o_bias1_en, o_bias2_en, o_mixin1_en, o_mixin1_mute, o_mixin1_ramp, o_input_mixer_one_zero_cross_update;
  logic o_mixin1_mix_sel, o_mixin2_en, o_mixin2_mute, o_mixin2_ramp, o_mixin2_zc, o_mixin2_mix_sel;
  int mismatches = 0;
  int num_checks = 0;
  int i, k;
  ripc_regs i_dut
  (
    .i_clk_sys, .i_rst, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .o_rdata, .o_rd_valid,
    .o_mic1_en, .o_mic1_mute, .o_mic1_gain, .o_mic1_src, .o_mic2_en, .o_mic2_mute, .o_mic2_gain,
    .o_mic2_src, .o_bias1_level, .o_bias2_level, .o_first_bias_low_power, .o_second_bias_low_power,
    .o_bias1_en, .o_bias2_en, .o_mixin1_en, .o_mixin1_mute, .o_mixin1_ramp,
    .o_input_mixer_one_zero_cross_update, .o_mixin1_mix_sel, .o_mixin1_gain, .o_mixin1_gain_mode_ramp,
    .o_mixin1_gain_mode_zc, .o_mixin2_en, .o_mixin2_mute, .o_mixin2_ramp, .o_mixin2_zc,
    .o_mixin2_mix_sel, .o_mixin2_gain
  );
  initial forever #25 i_clk_sys = ~i_clk_sys;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // field outputs gathered back into register layout, so they compare against the readback tables
  function automatic logic [7:0] view(input logic [7:0] a);
    case (a)
      8'h2c: view = {o_mixin1_en, o_mixin1_mute, o_mixin1_ramp, o_input_mixer_one_zero_cross_update,
        o_mixin1_mix_sel, 3'h0};
      8'h2d: view = {4'h0, o_mixin1_gain};
      8'h2e: view = {o_mixin2_en, o_mixin2_mute, o_mixin2_ramp, o_mixin2_zc, o_mixin2_mix_sel, 3'h0};
      8'h2f: view = {4'h0, o_mixin2_gain};
      8'hb4: view = {o_mic1_en, o_mic1_mute, 6'h00};
      8'hb5: view = {5'h00, o_mic1_gain};
      8'hb7: view = {6'h00, o_mic1_src};
      8'hb8: view = {o_mic2_en, o_mic2_mute, 6'h00};
      8'hb9: view = {5'h00, o_mic2_gain};
      8'hbb: view = {6'h00, o_mic2_src};
      8'hfc: view = {o_second_bias_low_power, o_bias2_level, o_first_bias_low_power, o_bias1_level};
      8'hfd: view = {3'h0, o_bias2_en, 3'h0, o_bias1_en};
      default: view = 8'h00;
    endcase
  endfunction
  // returns at a falling edge once the field outputs have followed the write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr_en <= 1'b0;
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    i_rd_en <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd_en <= 1'b0;
    @(negedge i_clk_sys);
    chk({7'h00, o_rd_valid}, 8'h01);
    chk(o_rdata, exp);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    for (i = 0; i < 12; i++)
    begin
      rd(ad_tab[i], rv_tab[i]);
      chk(view(ad_tab[i]), rv_tab[i]);
    end
    for (k = 0; k < 3; k++)
      for (i = 0; i < 12; i++)
      begin
        // bias level and mode may only move while the regulators are off
        if (ad_tab[i] == 8'hfc)
          wr(8'hfd, 8'h00);
        wr(ad_tab[i], pat_tab[k]);
        rd(ad_tab[i], pat_tab[k] & mk_tab[i]);
        chk(view(ad_tab[i]), pat_tab[k] & mk_tab[i]);
      end
    wr(8'hb6, 8'hff);
    rd(8'hb6, 8'h00);
    rd(8'hb7, 8'h02);
    for (k = 0; k < 4; k++)
    begin
      wr(8'hb7, k[7:0]);
      wr(8'hbb, 8'h03 - k[7:0]);
      chk({6'h00, o_mic1_src}, k[7:0]);
      chk({6'h00, o_mic2_src}, 8'h03 - k[7:0]);
    end
    wr(8'hfd, 8'h00);
    for (k = 0; k < 8; k++)
    begin
      wr(8'hfc, {1'b0, k[2:0], 1'b0, 3'h7 - k[2:0]});
      chk({5'h00, o_bias2_level}, k[7:0]);
      chk({5'h00, o_bias1_level}, 8'h07 - k[7:0]);
    end
    for (k = 0; k < 4; k++)
    begin
      wr(8'h2c, {2'b10, k[1:0], 4'h8});
      chk({7'h00, o_mixin1_gain_mode_ramp}, {7'h00, k[1]});
      chk({7'h00, o_mixin1_gain_mode_zc}, {7'h00, k == 1});
    end
    final_report;
  end
endmodule
